// File: pkg/aifs_pkg.sv
// Package of constants and types for the analog input fault and status words
package aifs_pkg;
   localparam int                NUM_CH         = 16;
   localparam int                ALARM_W        = 5;
   // Module summary word positions
   localparam int                MSW_GROUP_BIT  = 15;
   localparam int                MSW_CALIB_BIT  = 10;
   localparam int                MSW_CALERR_BIT = 9;
   localparam logic [15:0]       MSW_RESET      = 16'h0000;
   // Channel condition word positions
   localparam int                CCW_CALERR_BIT = 7;
   localparam int                CCW_BELOW_BIT  = 6;
   localparam int                CCW_ABOVE_BIT  = 5;
   localparam int                CCW_SLOPE_BIT  = 4;
   localparam int                CCW_LOW_BIT    = 3;
   localparam int                CCW_HIGH_BIT   = 2;
   localparam int                CCW_LOLO_BIT   = 1;
   localparam int                CCW_HIHI_BIT   = 0;
   localparam logic [7:0]        CCW_RESET      = 8'h00;
   // Fill patterns of the channel fault word
   localparam logic [15:0]       FILL_SINGLE    = 16'hFFFF;
   localparam logic [15:0]       FILL_DIFF      = 16'h00FF;
   localparam logic [15:0]       FILL_HSDIFF    = 16'h000F;
   localparam logic [15:0]       FILL_COMMLOSS  = 16'hFFFF;
   localparam logic [15:0]       PCFW_RESET     = 16'h0000;
   // Active channel counts
   localparam logic [4:0]        CNT_SINGLE     = 5'h10;
   localparam logic [4:0]        CNT_DIFF       = 5'h08;
   localparam logic [4:0]        CNT_HSDIFF     = 5'h04;

   // Wiring format
   typedef enum logic [1:0] {
      AIFS_WIRE_SINGLE = 2'h0,
      AIFS_WIRE_DIFF   = 2'h1,
      AIFS_WIRE_HSDIFF = 2'h3
   } aifs_wire_e;

   // Publication sequencer: idle, capture, publish
   typedef enum logic [1:0] {
      AIFS_ST_IDLE    = 2'h0,
      AIFS_ST_CAPTURE = 2'h1,
      AIFS_ST_PUBLISH = 2'h3
   } aifs_state_e;

   // Mask of active channels for a wiring format
   function automatic logic [15:0] active_mask(input aifs_wire_e wire_fmt);
      case (wire_fmt)
         AIFS_WIRE_SINGLE: active_mask = FILL_SINGLE;
         AIFS_WIRE_DIFF:   active_mask = FILL_DIFF;
         AIFS_WIRE_HSDIFF: active_mask = FILL_HSDIFF;
         default:          active_mask = FILL_SINGLE;
      endcase
   endfunction : active_mask
endpackage : aifs_pkg

// File: pkg/aifs_alarm_if.sv
// Interface carrying one channel's alarm inputs and latched results
interface aifs_alarm_if;
   logic [4:0] rawAlarm;
   logic [4:0] deadband;
   logic [4:0] latchEn;
   logic [4:0] unlatch;
   logic [4:0] alarmState;
   modport core (input rawAlarm, input deadband, input latchEn, input unlatch,
                 output alarmState);
   modport user (output rawAlarm, output deadband, output latchEn, output unlatch,
                 input alarmState);
endinterface : aifs_alarm_if

// File: src/aifs_alarm_latch.sv
// Alarm holding logic for one channel: trigger, deadband hold and latching
module aifs_alarm_latch (
   // Clock and reset
   input  wire logic   clock,
   input  wire logic   reset_n,
   // Alarm group
   aifs_alarm_if.core  alm
);
   logic [4:0] alarm_r;

   // R14 hold and latch
   // Set wins over unlatch so a fresh trip in the clearing cycle stays visible
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         alarm_r <= 5'h00;
      end else begin
         alarm_r <= alm.rawAlarm
                  | (alarm_r & alm.deadband)
                  | (alarm_r & alm.latchEn & ~alm.unlatch);
      end
   end

   assign alm.alarmState = alarm_r;
endmodule : aifs_alarm_latch

// File: src/aifs_fault_status.sv
// Fault and status word aggregation for a sixteen-channel analog input module
// Behaviour
// R1: The fault and status words are published together with each channel data multicast.
// R2: Summary bit 15 is set whenever any channel fault word bit is set.
// R3: Summary bit 10 is set while any channel is being calibrated.
// R4: Summary bit 9 is the OR of all per-channel calibration error bits.
// R5: Summary bits 11 to 14 always read zero.
// R6: In normal operation channel fault bit n follows channel n below or above range.
// R7: Active channels are 16 single-ended, 8 differential, 4 high-speed differential.
// R8: During calibration the fault word is FFFF, 00FF or 000F by wiring format.
// R9: On loss of owner communication the fault word reads FFFF in any format.
// R10: Condition word bits are cal error, below, above, slope, low, high, low-low, high-high.
// R11: One condition word exists per active channel; inactive ones read zero.
// R12: Process and slope alarms never reach the fault or summary words.
// R13: Below range when input is at or under minimum, above when at or over maximum.
// R14: Alarms clear past the trigger point unless held by deadband or latching.
// R15: After reset every word reads zero until a conversion and link state are seen; the code waits only for the first conversion.
module aifs_fault_status (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        reset_n,
   // Configuration
   input  wire aifs_pkg::aifs_wire_e        wireFormat,
   // Conversion results: done strobe, one sample per channel, shared range limits
   input  wire logic                        convDone,
   input  wire logic signed [15:0]          sampleValue [16],
   input  wire logic signed [15:0]          minDetect,
   input  wire logic signed [15:0]          maxDetect,
   // Calibration state per channel
   input  wire logic [15:0]                 calBusy,
   input  wire logic [15:0]                 calError,
   // Alarm detector results per channel, bit order slope, low, high, low-low, high-high
   input  wire logic [4:0]                  rawAlarm [16],
   input  wire logic [4:0]                  deadbandHold [16],
   input  wire logic [4:0]                  latchEnable [16],
   input  wire logic [4:0]                  unlatchReq [16],
   // Owner link
   input  wire logic                        commLost,
   input  wire logic                        multicastReq,
   // Published words
   output logic [15:0]                      module_summary_word,
   output logic [15:0]                      per_channel_fault_word,
   output logic [7:0]                       channel_condition_word [16],
   output logic [4:0]                       activeCount,
   output logic                             multicastValid
);
   aifs_pkg::aifs_state_e state_r;
   aifs_pkg::aifs_state_e state_nxt;
   logic [15:0]           below;
   logic [15:0]           above;
   logic [15:0]           actMask;
   logic [15:0]           faultWord;
   logic [15:0]           summaryWord;
   logic [7:0]            condWord [16];
   logic [4:0]            alarmHeld [16];
   logic                  seenConv_r;
   logic                  commA_r;
   logic                  commB_r;
   logic                  commC_r;
   logic                  commLost_r;

   // Owner link status comes from another domain, three stages then agree
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         commA_r <= 1'b0;
         commB_r <= 1'b0;
         commC_r <= 1'b0;
      end else begin
         commA_r <= commLost;
         commB_r <= commA_r;
         commC_r <= commB_r;
      end
   end

   // Accepted link state changes only when the last two stages agree
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         commLost_r <= 1'b0;
      end else if (commB_r == commC_r) begin
         commLost_r <= commC_r;
      end
   end

   // R15 first conversion seen
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         seenConv_r <= 1'b0;
      end else if (convDone) begin
         seenConv_r <= 1'b1;
      end
   end

   // R7 active channel mask
   assign actMask = aifs_pkg::active_mask(wireFormat);

   // Per-channel alarm holding and range compare
   for (genvar ch = 0; ch < aifs_pkg::NUM_CH; ch++) begin : g_ch
      aifs_alarm_if alm ();
      assign alm.rawAlarm = rawAlarm[ch];
      assign alm.deadband = deadbandHold[ch];
      assign alm.latchEn  = latchEnable[ch];
      assign alm.unlatch  = unlatchReq[ch];
      assign alarmHeld[ch] = alm.alarmState;

      aifs_alarm_latch u_alarm (
         .clock   (clock),
         .reset_n (reset_n),
         .alm     (alm)
      );

      // R13 inclusive range limits
      assign below[ch] = actMask[ch] && (sampleValue[ch] <= minDetect);
      assign above[ch] = actMask[ch] && (sampleValue[ch] >= maxDetect);

      // R10 condition word layout
      // R11 inactive channels read zero
      always_comb begin
         condWord[ch] = aifs_pkg::CCW_RESET;
         if (actMask[ch]) begin
            condWord[ch][aifs_pkg::CCW_CALERR_BIT] = calError[ch];
            condWord[ch][aifs_pkg::CCW_BELOW_BIT]  = below[ch];
            condWord[ch][aifs_pkg::CCW_ABOVE_BIT]  = above[ch];
            condWord[ch][aifs_pkg::CCW_SLOPE_BIT]  = alarmHeld[ch][4];
            condWord[ch][aifs_pkg::CCW_LOW_BIT]    = alarmHeld[ch][3];
            condWord[ch][aifs_pkg::CCW_HIGH_BIT]   = alarmHeld[ch][2];
            condWord[ch][aifs_pkg::CCW_LOLO_BIT]   = alarmHeld[ch][1];
            condWord[ch][aifs_pkg::CCW_HIHI_BIT]   = alarmHeld[ch][0];
         end
      end
   end

   // Channel fault word with fill priority: link loss, then calibration
   always_comb begin
      if (commLost_r) begin
         // R9 link loss fill
         faultWord = aifs_pkg::FILL_COMMLOSS;
      end else if (|(calBusy & actMask)) begin
         // R8 calibration fill
         faultWord = actMask;
      end else begin
         // R6 range faults only
         // R12 alarms excluded
         faultWord = below | above;
      end
   end

   // Summary word; unused bits stay zero
   always_comb begin
      summaryWord = aifs_pkg::MSW_RESET;
      // R2 group summary
      summaryWord[aifs_pkg::MSW_GROUP_BIT]  = |faultWord;
      // R3 calibrating flag
      summaryWord[aifs_pkg::MSW_CALIB_BIT]  = |(calBusy & actMask);
      // R4 calibration error OR
      summaryWord[aifs_pkg::MSW_CALERR_BIT] = |(calError & actMask);
      // R5 bits 11 to 14 zero by the default above
   end

   // Sequencer: capture on request, publish for one cycle
   always_comb begin
      case (state_r)
         aifs_pkg::AIFS_ST_IDLE:    state_nxt = (multicastReq && seenConv_r)
                                               ? aifs_pkg::AIFS_ST_CAPTURE
                                               : aifs_pkg::AIFS_ST_IDLE;
         aifs_pkg::AIFS_ST_CAPTURE: state_nxt = aifs_pkg::AIFS_ST_PUBLISH;
         aifs_pkg::AIFS_ST_PUBLISH: state_nxt = aifs_pkg::AIFS_ST_IDLE;
         default:                   state_nxt = aifs_pkg::AIFS_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= aifs_pkg::AIFS_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // R1 words captured together with the multicast
   // R15 cleared at reset, held zero until first conversion
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         module_summary_word    <= aifs_pkg::MSW_RESET;
         per_channel_fault_word <= aifs_pkg::PCFW_RESET;
         for (int i = 0; i < aifs_pkg::NUM_CH; i++) begin
            channel_condition_word[i] <= aifs_pkg::CCW_RESET;
         end
      end else if (state_r == aifs_pkg::AIFS_ST_CAPTURE) begin
         module_summary_word    <= summaryWord;
         per_channel_fault_word <= faultWord;
         for (int i = 0; i < aifs_pkg::NUM_CH; i++) begin
            channel_condition_word[i] <= condWord[i];
         end
      end
   end

   // Valid marks the cycle in which the captured set is stable
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         multicastValid <= 1'b0;
      end else begin
         multicastValid <= (state_nxt == aifs_pkg::AIFS_ST_PUBLISH);
      end
   end

   // R7 and R11 number of condition words published
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         activeCount <= aifs_pkg::CNT_SINGLE;
      end else begin
         case (wireFormat)
            aifs_pkg::AIFS_WIRE_SINGLE: activeCount <= aifs_pkg::CNT_SINGLE;
            aifs_pkg::AIFS_WIRE_DIFF:   activeCount <= aifs_pkg::CNT_DIFF;
            aifs_pkg::AIFS_WIRE_HSDIFF: activeCount <= aifs_pkg::CNT_HSDIFF;
            default:                    activeCount <= aifs_pkg::CNT_SINGLE;
         endcase
      end
   end
endmodule : aifs_fault_status

// File: dv/aifs_fault_status_properties.sv
// Checker of the fault and status word relations at the block's ports
module aifs_fault_status_properties (
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 reset_n,
   // Inputs watched
   input wire aifs_pkg::aifs_wire_e wireFormat,
   input wire logic [15:0]          calBusy,
   input wire logic [15:0]          calError,
   input wire logic                 commLost,
   // Published words
   input wire logic [15:0]          module_summary_word,
   input wire logic [15:0]          per_channel_fault_word,
   input wire logic [7:0]           channel_condition_word [16],
   input wire logic [4:0]           activeCount,
   input wire logic                 multicastValid
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] actMask;
   logic [15:0] rangeBits;
   logic [15:0] usedBits;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Active mask and per-channel summaries; mask taken from the count so the two must agree
   always_comb begin
      actMask = (activeCount == 5'h08) ? 16'h00FF : (activeCount == 5'h04) ? 16'h000F : 16'hFFFF;
      for (int n = 0; n < 16; n++) begin
         rangeBits[n] = channel_condition_word[n][6] | channel_condition_word[n][5];
         usedBits[n]  = |channel_condition_word[n];
      end
   end
   // Link state the same now and five cycles back, past the synchroniser
   sequence s_pub_ok;
      multicastValid && !commLost && !$past(commLost, 5);
   endsequence
   sequence s_pub_lost;
      multicastValid && commLost && $past(commLost, 5);
   endsequence
   sequence s_quiet;
      !multicastValid [*2];
   endsequence
   a_group_fault: assert property (multicastValid |-> module_summary_word[15] == |per_channel_fault_word)
      else $error("group fault bit wrong");
   a_calib_flag: assert property (multicastValid |-> module_summary_word[10] == |($past(calBusy) & actMask))
      else $error("calibrating bit wrong");
   a_calerr_sum: assert property (multicastValid |-> module_summary_word[9] == |($past(calError) & actMask))
      else $error("calibration error summary wrong");
   a_unused_zero: assert property (module_summary_word[14:11] == 4'h0 && module_summary_word[8:0] == 9'h000)
      else $error("unused summary bits set");
   a_range_fault: assert property (s_pub_ok ##0 !module_summary_word[10] |-> per_channel_fault_word == (rangeBits & actMask))
      else $error("fault word not range bits");
   a_calib_fill: assert property (s_pub_ok ##0 module_summary_word[10] |-> per_channel_fault_word == actMask)
      else $error("calibration fill wrong");
   a_comm_fill: assert property (s_pub_lost |-> per_channel_fault_word == 16'hFFFF)
      else $error("link loss fill wrong");
   a_count_follow: assert property (activeCount == (($past(wireFormat) == aifs_pkg::AIFS_WIRE_DIFF) ? 5'h08 :
      ($past(wireFormat) == aifs_pkg::AIFS_WIRE_HSDIFF) ? 5'h04 : 5'h10)) else $error("active count wrong");
   a_inactive_zero: assert property (multicastValid |-> (usedBits & ~actMask) == 16'h0000)
      else $error("inactive condition word set");
   a_valid_pulse: assert property ($rose(multicastValid) |=> s_quiet)
      else $error("valid pulse too long");
endmodule : aifs_fault_status_properties

bind aifs_fault_status aifs_fault_status_properties u_props (.clock, .reset_n, .wireFormat,
   .calBusy, .calError, .commLost, .module_summary_word, .per_channel_fault_word,
   .channel_condition_word, .activeCount, .multicastValid);

// File: dv/aifs_owner_model.sv
// Owner controller model: asks for publications and keeps each received set
module aifs_owner_model (
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // Bench control and published words
   input wire logic        ask,
   input wire logic        multicastValid,
   input wire logic [15:0] module_summary_word,
   input wire logic [15:0] per_channel_fault_word,
   // Request and received copies
   output logic            multicastReq,
   output logic [15:0]     rxSummary,
   output logic [15:0]     rxFault,
   output logic [7:0]      rxCount
);
   timeunit 1ns;
   timeprecision 100ps;
   // One request per ask; asks come far apart, so spacing is never broken
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         multicastReq <= 1'b0;
      end else begin
         multicastReq <= ask;
      end
   end
   // Valid stands one cycle, so the summary and fault words are copied at that edge
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxSummary <= 16'h0000;
         rxFault   <= 16'h0000;
         rxCount   <= 8'h00;
      end else if (multicastValid) begin
         rxSummary <= module_summary_word;
         rxFault   <= per_channel_fault_word;
         rxCount   <= rxCount + 8'h01;
      end
   end
endmodule : aifs_owner_model

// File: dv/testbench.sv
// Self-checking bench for the analog input fault and status words
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 clock = 1'b0;
   logic                 reset_n = 1'b0;
   aifs_pkg::aifs_wire_e wireFormat = aifs_pkg::AIFS_WIRE_SINGLE;
   logic                 convDone = 1'b0;
   logic                 commLost = 1'b0;
   logic                 ask = 1'b0;
   logic signed [15:0]   sampleValue [16] = '{default: 16'sh0000};
   logic signed [15:0]   minDetect = 16'shC000;
   logic signed [15:0]   maxDetect = 16'sh4000;
   logic [15:0]          calBusy = 16'h0000;
   logic [15:0]          calError = 16'h0000;
   logic [4:0]           rawAlarm [16] = '{default: 5'h00};
   logic [4:0]           deadbandHold [16] = '{default: 5'h00};
   logic [4:0]           latchEnable [16] = '{default: 5'h00};
   logic [4:0]           unlatchReq [16] = '{default: 5'h00};
   logic [4:0]           expAlarm [16] = '{default: 5'h00};
   logic                 multicastReq;
   logic                 multicastValid;
   logic [15:0]          msWord, pcfWord, rxSummary, rxFault;
   logic [7:0]           ccWord [16];
   logic [7:0]           rxCount;
   logic [4:0]           activeCount;
   logic [31:0]          seed = 32'h00013E11;
   int                   miscompares = 0;
   int                   numChecks = 0;
   int                   cycles = 0;

   aifs_fault_status dut (.clock, .reset_n, .wireFormat, .convDone, .sampleValue, .minDetect,
      .maxDetect, .calBusy, .calError, .rawAlarm, .deadbandHold,
      .latchEnable, .unlatchReq, .commLost, .multicastReq,
      .module_summary_word(msWord), .per_channel_fault_word(pcfWord),
      .channel_condition_word(ccWord), .activeCount, .multicastValid);
   aifs_owner_model owner (.clock, .reset_n, .ask, .multicastValid,
      .module_summary_word(msWord), .per_channel_fault_word(pcfWord), .multicastReq,
      .rxSummary, .rxFault, .rxCount);

   // Clock and hang guard; the run needs about 700 cycles
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         $display("mismatch at %0t: run timed out", $time);
         wrap_up();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [15:0] mask_of(input logic [1:0] f);
      return (f == 2'h1) ? 16'h00FF : (f == 2'h3) ? 16'h000F : 16'hFFFF;
   endfunction : mask_of
   // Settled alarm state: a fresh trip, or the earlier state kept by deadband or latch
   function automatic logic [4:0] hold_next(input logic [4:0] a, input logic [4:0] prev,
      input logic [4:0] d, input logic [4:0] l, input logic [4:0] u);
      return a | (prev & (d | (l & ~u)));
   endfunction : hold_next
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Random inputs; the first four rounds walk every format code with channel 0 calibrating
   task automatic stir(input int i);
      logic [31:0] r;
      logic [4:0]  a, d, l, u;
      @(posedge clock);
      r = rnd();
      wireFormat <= aifs_pkg::aifs_wire_e'((i < 4) ? i[1:0] : r[1:0]);
      calBusy    <= (i < 4) ? 16'h0001 : (r[6:4] == 3'h0) ? 16'h0001 << r[11:8] : 16'h0000;
      calError   <= rnd() & rnd();
      commLost   <= (i == 4) || (r[14:12] == 3'h0);
      for (int n = 0; n < 16; n++) begin
         a = 5'(rnd());
         d = 5'(rnd());
         l = 5'(rnd());
         u = 5'(rnd());
         sampleValue[n] <= (i % 2 == 1 && n < 3) ? ((n == 0) ? minDetect : (n == 1) ? maxDetect
                           : minDetect + 16'sh0001) : 16'(rnd());
         rawAlarm[n]     <= a;
         deadbandHold[n] <= d;
         latchEnable[n]  <= l;
         unlatchReq[n]   <= u;
         expAlarm[n]     = hold_next(a, expAlarm[n], d, l, u);
      end
   endtask : stir
   // Ask once and wait a bounded time for the received count to move
   task automatic publish();
      logic [7:0] startCount;
      startCount = rxCount;
      ask <= 1'b1;
      @(posedge clock);
      ask <= 1'b0;
      for (int k = 0; k < 12 && rxCount == startCount; k++) @(posedge clock);
   endtask : publish
   task automatic check_all();
      logic [15:0] m, rng, f;
      logic [7:0]  c;
      m = mask_of(wireFormat);
      for (int n = 0; n < 16; n++) rng[n] = sampleValue[n] <= minDetect || sampleValue[n] >= maxDetect;
      f = commLost ? 16'hFFFF : (|(calBusy & m)) ? m : (rng & m);
      chk16(rxFault, f);
      chk16(rxSummary, {|f, 4'h0, |(calBusy & m), |(calError & m), 9'h000});
      chk8({3'h0, activeCount}, 8'($countones(m)));
      for (int n = 0; n < 16; n++) begin
         c = m[n] ? {calError[n], sampleValue[n] <= minDetect, sampleValue[n] >= maxDetect,
                     expAlarm[n]} : 8'h00;
         chk8(ccWord[n], c);
      end
   endtask : check_all

   initial begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk16(msWord, 16'h0000);
      chk16(pcfWord, 16'h0000);
      chk8({3'h0, activeCount}, 8'h10);
      publish();
      chk8(rxCount, 8'h00);
      convDone <= 1'b1;
      for (int i = 0; i < 48; i++) begin
         stir(i);
         repeat (8) @(posedge clock);
         publish();
         chk8(rxCount, 8'(i + 1));
         check_all();
      end
      wrap_up();
   end
endmodule : testbench
